/* File: rtl/sim_pkg.sv */
// sim_pkg: constants, register map and carrier types of the safe input monitor.
// assumes one 100 MHz system clock and a plain strobe register port.
package sim_pkg;
	// clock and time base
	localparam int CLK_MHZ = 100;
	localparam int TICK_US = 1000; // one millisecond time base
	localparam int TICK_CYC = TICK_US * CLK_MHZ;
	localparam int TEST_US = 10; // per path switch-off hold during self-test
	localparam int TEST_CYC = TEST_US * CLK_MHZ;
	// register byte addresses
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_TOL = 8'h04;
	localparam logic [7:0] ADR_DEB = 8'h08;
	localparam logic [7:0] ADR_IVL = 8'h0C;
	localparam logic [7:0] ADR_REM = 8'h10;
	localparam logic [7:0] ADR_STAT = 8'h14;
	localparam logic [7:0] ADR_SDEB = 8'h18;
	localparam logic [7:0] ADR_TGL = 8'h1C;
	// control bits
	localparam int CTRL_EN = 0;
	localparam int CTRL_CLR = 1;
	// status bits
	localparam int ST_DISC = 0;
	localparam int ST_TOA = 1;
	localparam int ST_WIRE = 2;
	localparam int ST_TGL = 3;
	localparam int ST_TRUN = 4;
	localparam int ST_TFAIL = 5;
	localparam int ST_TREQ = 6;
	localparam int ST_FA = 7;
	localparam int ST_FB = 8;
	// toggle monitor field layout
	localparam int TGL_LIM_LSB = 0;
	localparam int TGL_WIN_LSB = 8;
	// reset values, times in milliseconds
	localparam logic [15:0] TOL_RST = 16'h01F4; // 500 ms
	localparam logic [7:0] DEB_RST = 8'h01; // 1 ms
	localparam logic [31:0] IVL_RST = 32'h01B7_7400; // 8 h
	localparam logic [7:0] SDEB_RST = 8'h01;
	localparam logic [7:0] TGL_LIM_RST = 8'h0A;
	localparam logic [15:0] TGL_WIN_RST = 16'h03E8; // 1 s
	// path indices of the self-test
	localparam logic [1:0] PATH_A = 2'h0;
	localparam logic [1:0] PATH_B = 2'h1;
	localparam logic [1:0] PATH_BRK = 2'h2;

	typedef enum logic [0:0] {SIM_IDLE, SIM_RUN} sim_test_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} sim_bus_s;

	typedef struct packed {
		logic fail_safe_a;
		logic fail_safe_b;
		logic std_in;
	} sim_in_s;

	typedef struct packed {
		logic [2:0] path_fb;
		logic brake_fitted;
	} sim_fb_s;
endpackage

/* File: rtl/sim_monitor.sv */
// sim_monitor: dual-channel fail-safe input monitor with torque switch-off selection,
// discrepancy and toggle supervision, and a recurring switch-off path self-test.
// assumes synchronous inputs, a 100 MHz sys_clk and a one-cycle-latency register port.
// Summary of operation
// RULE1: enable 0 inhibits everything; enable 1 allows terminal torque switch-off selection. Here the self-test and recurrence timer still run at enable 0.
// RULE2: torque-off-active status reads 1 while torque switch-off is in effect.
// RULE3: both filtered channels are compared continuously; a difference flags discrepancy.
// RULE4: discrepancy beyond tolerance time, default 500 ms, latches a wiring fault.
// RULE5: either channel falling selects torque switch-off, never delayed by tolerance.
// RULE6: adjustable debounce filter, default 1 ms, hides bounce and test pulses.
// RULE7: with filtering, switch-off follows only after the change persisted the debounce time.
// RULE8: too many input level changes within a monitoring window raise a fault.
// RULE9: the driving controller may apply on/off test pulses of about 1 ms.
// RULE10: safe input and ordinary input debounce settings are fully independent.
// RULE11: self-test runs at power-up and on each switch-off selection, brake path included.
// RULE12: self-test forces each switch-off path and checks its feedback.
// RULE13: recurrence timer, default 8 h, counts down from the last completed test.
// RULE14: remaining timer value is readable at all times.
// RULE15: timer expiry sets a test-required status bit, also driven to a pin.
// RULE16: the test-due warning is informational and leaves motor operation untouched.
// RULE17: the controller then stops the motor and triggers a test itself.
// RULE18: the operator ensures a self-test at least once a year.
// RULE19: a passed self-test reloads the timer and clears the test-required bit.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module sim_monitor import sim_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYC,
	parameter int TEST_CYCLES = TEST_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// register port
	input wire sim_bus_s bus,
	output logic [31:0] rdata,
	// terminal inputs
	input wire sim_in_s pins,
	// switch-off path feedback
	input wire sim_fb_s fb,
	// outputs
	output logic [2:0] path_off,
	output logic torque_off_active_flag,
	output logic selftest_required_flag,
	output logic selftest_due_warning,
	output logic std_in_filtered
);
	localparam logic [31:0] TICK_M1 = 32'(TICK_CYCLES - 1);
	localparam logic [31:0] TEST_M1 = 32'(TEST_CYCLES - 1);

	typedef struct packed {
		logic enable;
		logic [15:0] tol;
		logic [7:0] deb;
		logic [31:0] ivl;
		logic [7:0] sdeb;
		logic [7:0] tgl_lim;
		logic [15:0] tgl_win;
		logic [31:0] rdata;
		logic [31:0] tick_cnt;
		logic [2:0] filt;
		logic [2:0] raw_q;
		logic [31:0] deb_cnt0;
		logic [31:0] deb_cnt1;
		logic [31:0] deb_cnt2;
		logic [15:0] disc_ms;
		logic wire_flt;
		logic [7:0] chg_cnt;
		logic [15:0] win_ms;
		logic tgl_flt;
		logic sel_q;
		logic test_pend;
		sim_test_e tst;
		logic [1:0] tidx;
		logic [31:0] tcnt;
		logic tfail;
		logic [31:0] remain;
		logic treq;
		logic warn;
		logic toa;
		logic [2:0] poff;
	} sim_state_s;

	localparam sim_state_s RST_VAL = '{
		enable: 1'b0, tol: TOL_RST, deb: DEB_RST, ivl: IVL_RST, sdeb: SDEB_RST,
		tgl_lim: TGL_LIM_RST, tgl_win: TGL_WIN_RST, rdata: 32'h0, tick_cnt: 32'h0,
		filt: 3'h7, raw_q: 3'h7, deb_cnt0: 32'h0, deb_cnt1: 32'h0, deb_cnt2: 32'h0,
		disc_ms: 16'h0, wire_flt: 1'b0, chg_cnt: 8'h0, win_ms: 16'h0, tgl_flt: 1'b0,
		sel_q: 1'b0, test_pend: 1'b1, tst: SIM_IDLE, tidx: 2'h0, tcnt: 32'h0,
		tfail: 1'b0, remain: IVL_RST, treq: 1'b0, warn: 1'b0, toa: 1'b0, poff: 3'h7
	};

	sim_state_s r;
	sim_state_s next_r;
	logic [2:0] raw;
	logic [31:0] thr [3];
	logic [31:0] cnt_q [3];
	logic [31:0] cnt_d [3];
	logic tick;
	logic sel;
	logic clr;
	logic pass;
	logic [1:0] last_idx;
	logic [31:0] status;

	assign raw = {pins.std_in, pins.fail_safe_b, pins.fail_safe_a};
	assign tick = (r.tick_cnt == TICK_M1);
	assign clr = bus.wr && (bus.addr == ADR_CTRL) && bus.wdata[CTRL_CLR];
	assign last_idx = fb.brake_fitted ? PATH_BRK : PATH_B;
	assign cnt_q[0] = r.deb_cnt0;
	assign cnt_q[1] = r.deb_cnt1;
	assign cnt_q[2] = r.deb_cnt2;
	// safe channels share one setting, the ordinary input has its own [RULE10]
	assign thr[0] = 32'(r.deb) * 32'(TICK_CYCLES);
	assign thr[1] = 32'(r.deb) * 32'(TICK_CYCLES);
	assign thr[2] = 32'(r.sdeb) * 32'(TICK_CYCLES);

	// per-input debounce: a level is taken only after it held the full time [RULE6] [RULE7]
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_deb
			always_comb begin
				if (raw[gi] == r.filt[gi]) begin
					cnt_d[gi] = 32'h0;
				end else begin
					cnt_d[gi] = cnt_q[gi] + 32'h1;
				end
			end
		end
	endgenerate

	// selection follows the first falling filtered channel, tolerance plays no part [RULE5]
	assign sel = r.enable && (!r.filt[0] || !r.filt[1]); // [RULE1]
	assign pass = (r.tst == SIM_RUN) && (r.tcnt == TEST_M1) && fb.path_fb[r.tidx]
		&& (r.tidx == last_idx) && !r.tfail;

	// status word gathered for reads
	always_comb begin
		status = 32'h0;
		status[ST_DISC] = r.enable && (r.filt[0] ^ r.filt[1]);
		status[ST_TOA] = r.toa;
		status[ST_WIRE] = r.wire_flt;
		status[ST_TGL] = r.tgl_flt;
		status[ST_TRUN] = (r.tst == SIM_RUN);
		status[ST_TFAIL] = r.tfail;
		status[ST_TREQ] = r.treq;
		status[ST_FA] = r.filt[0];
		status[ST_FB] = r.filt[1];
	end

	// whole next-state computation
	always_comb begin
		next_r = r;
		next_r.tick_cnt = tick ? 32'h0 : r.tick_cnt + 32'h1;
		next_r.raw_q = raw;
		next_r.warn = 1'b0;

		// register writes
		if (bus.wr) begin
			case (bus.addr)
				ADR_CTRL: next_r.enable = bus.wdata[CTRL_EN];
				ADR_TOL: next_r.tol = bus.wdata[15:0];
				ADR_DEB: next_r.deb = bus.wdata[7:0];
				ADR_IVL: next_r.ivl = bus.wdata;
				ADR_SDEB: next_r.sdeb = bus.wdata[7:0];
				ADR_TGL: begin
					next_r.tgl_lim = bus.wdata[TGL_LIM_LSB +: 8];
					next_r.tgl_win = bus.wdata[TGL_WIN_LSB +: 16];
				end
				default: ;
			endcase
		end

		// read data stand only in the cycle after the strobe; unmapped reads give zero
		next_r.rdata = 32'h0;
		if (bus.rd) begin
			case (bus.addr)
				ADR_CTRL: next_r.rdata = {31'h0, r.enable};
				ADR_TOL: next_r.rdata = {16'h0, r.tol};
				ADR_DEB: next_r.rdata = {24'h0, r.deb};
				ADR_IVL: next_r.rdata = r.ivl;
				ADR_REM: next_r.rdata = r.remain; // [RULE14]
				ADR_STAT: next_r.rdata = status;
				ADR_SDEB: next_r.rdata = {24'h0, r.sdeb};
				ADR_TGL: next_r.rdata = {8'h0, r.tgl_win, r.tgl_lim};
				default: next_r.rdata = 32'h0;
			endcase
		end

		// debounce counters and filtered levels; zero time means next cycle
		next_r.deb_cnt0 = cnt_d[0];
		next_r.deb_cnt1 = cnt_d[1];
		next_r.deb_cnt2 = cnt_d[2];
		for (int i = 0; i < 3; i++) begin
			if (raw[i] != r.filt[i] && cnt_d[i] >= thr[i]) begin
				next_r.filt[i] = raw[i];
			end
		end
		next_r.deb_cnt0 = (next_r.filt[0] != r.filt[0]) ? 32'h0 : cnt_d[0];
		next_r.deb_cnt1 = (next_r.filt[1] != r.filt[1]) ? 32'h0 : cnt_d[1];
		next_r.deb_cnt2 = (next_r.filt[2] != r.filt[2]) ? 32'h0 : cnt_d[2];

		// discrepancy timing in milliseconds; a lasting one is a wiring fault [RULE3] [RULE4]
		if (!r.enable || !(r.filt[0] ^ r.filt[1])) begin
			next_r.disc_ms = 16'h0;
		end else if (tick && r.disc_ms != 16'hFFFF) begin
			next_r.disc_ms = r.disc_ms + 16'h1;
		end
		if (clr) begin
			next_r.wire_flt = 1'b0;
			next_r.tgl_flt = 1'b0;
			next_r.tfail = 1'b0;
		end
		// set wins over a clear in the same cycle
		if (r.enable && (r.filt[0] ^ r.filt[1]) && r.disc_ms >= r.tol && tick) begin
			next_r.wire_flt = 1'b1; // [RULE4]
		end

		// raw level changes counted per window; test pulses are counted too [RULE8]
		if (tick && r.win_ms + 16'h1 >= r.tgl_win) begin
			next_r.win_ms = 16'h0;
			next_r.chg_cnt = 8'h0;
		end else begin
			if (tick) begin
				next_r.win_ms = r.win_ms + 16'h1;
			end
			if ((raw[1:0] != r.raw_q[1:0]) && r.chg_cnt != 8'hFF) begin
				next_r.chg_cnt = r.chg_cnt + 8'h1;
			end
		end
		if (r.enable && r.chg_cnt > r.tgl_lim) begin
			next_r.tgl_flt = 1'b1; // [RULE8]
		end

		// torque-off is on while selected or after any latched fault; off when inhibited
		next_r.sel_q = sel;
		next_r.toa = r.enable && (sel || r.wire_flt || r.tgl_flt || r.tfail); // [RULE1] [RULE2]
		if (sel && !r.sel_q) begin
			next_r.test_pend = 1'b1; // [RULE11]
		end

		// self-test: hold each path off, then require its off feedback [RULE12]
		case (r.tst)
			SIM_IDLE: begin
				if (r.test_pend) begin
					next_r.test_pend = 1'b0;
					next_r.tst = SIM_RUN;
					next_r.tidx = PATH_A;
					next_r.tcnt = 32'h0;
				end
			end
			SIM_RUN: begin
				if (r.tcnt == TEST_M1) begin
					next_r.tcnt = 32'h0;
					if (!fb.path_fb[r.tidx]) begin
						next_r.tfail = 1'b1;
					end
					if (r.tidx == last_idx) begin
						next_r.tst = SIM_IDLE; // brake path included when fitted [RULE11]
					end else begin
						next_r.tidx = r.tidx + 2'h1;
					end
				end else begin
					next_r.tcnt = r.tcnt + 32'h1;
				end
			end
			default: next_r.tst = SIM_IDLE;
		endcase

		// recurrence timer counts down per millisecond [RULE13]
		if (pass) begin
			next_r.remain = r.ivl; // [RULE19]
			next_r.treq = 1'b0;
		end else if (tick && r.remain != 32'h0) begin
			next_r.remain = r.remain - 32'h1;
			if (r.remain == 32'h1) begin
				next_r.treq = 1'b1; // [RULE15]
				next_r.warn = 1'b1;
			end
		end

		// paths follow torque-off; the test adds one path at a time
		next_r.poff = {3{next_r.toa}};
		if (next_r.tst == SIM_RUN) begin
			next_r.poff[next_r.tidx] = 1'b1;
		end
	end

	// state register; reset starts a power-up test
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			r <= RST_VAL;
		end else begin
			r <= next_r;
		end
	end

	// outputs straight from flops; the warning never touches path drive [RULE16]
	assign rdata = r.rdata;
	assign path_off = r.poff;
	assign torque_off_active_flag = r.toa;
	assign selftest_required_flag = r.treq;
	assign selftest_due_warning = r.warn;
	assign std_in_filtered = r.filt[2];
endmodule // sim_monitor

/* File: bench/sim_monitor_props.sv */
// sim_monitor_props: port assertions for the safe input monitor.
// assumes a debounce of 2 ms or less; bound to every sim_monitor.
`timescale 1ns/10ps
module sim_monitor_props import sim_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYC,
	parameter int TEST_CYCLES = TEST_CYC
) (
	// clock, reset, bus
	input wire logic sys_clk,
	input wire logic rst,
	input wire sim_bus_s bus,
	input wire logic [31:0] rdata,
	// terminals
	input wire sim_in_s pins,
	input wire sim_fb_s fb,
	// outputs
	input wire logic [2:0] path_off,
	input wire logic torque_off_active_flag,
	input wire logic selftest_required_flag,
	input wire logic selftest_due_warning,
	input wire logic std_in_filtered
);
	logic en_q;
	logic [7:0] low_cnt;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// shadow enable and a saturating count of cycles with a channel low
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			en_q <= 1'b0;
			low_cnt <= 8'h00;
		end else begin
			if (bus.wr && bus.addr == ADR_CTRL) en_q <= bus.wdata[CTRL_EN];
			if (pins.fail_safe_a && pins.fail_safe_b) low_cnt <= 8'h00;
			else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
		end
	end
	sequence s_walk_a;
		##[1:20] path_off == 3'b001;
	endsequence
	a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
		else $error("read data not zero outside read slot");
	a_inhibit_off: assert property (!en_q && !$past(en_q) |-> !torque_off_active_flag)
		else $error("torque off while inhibited");
	a_low_forces_off: assert property (en_q && low_cnt == 8'h19 |-> torque_off_active_flag)
		else $error("low channel did not select torque off");
	a_powerup_walk: assert property ($fell(rst) |-> s_walk_a)
		else $error("no power-up path test");
	a_std_hold: assert property ($changed(std_in_filtered) |->
		std_in_filtered == $past(pins.std_in) && std_in_filtered == $past(pins.std_in, 6))
		else $error("ordinary input filter too fast");
	a_warn_pulse: assert property (selftest_due_warning |=> !selftest_due_warning)
		else $error("warning longer than one cycle");
	a_warn_req: assert property ($rose(selftest_required_flag) |-> selftest_due_warning)
		else $error("test required set without warning");
	a_req_clear_test: assert property ($fell(selftest_required_flag) |-> $past(path_off) != 3'b000)
		else $error("test required cleared without a test");
endmodule // sim_monitor_props
bind sim_monitor sim_monitor_props #(.TICK_CYCLES(TICK_CYCLES), .TEST_CYCLES(TEST_CYCLES))
	sim_monitor_props_inst (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata), .pins(pins),
	.fb(fb), .path_off(path_off), .torque_off_active_flag(torque_off_active_flag),
	.selftest_required_flag(selftest_required_flag), .selftest_due_warning(selftest_due_warning),
	.std_in_filtered(std_in_filtered));

/* File: bench/sim_sensor.sv */
// sim_sensor: dual-contact safety sensor plus switch-off feedback relays.
// assumes bench commands change just after a rising edge.
`timescale 1ns/10ps
module sim_sensor import sim_pkg::*; (
	// commands
	input wire logic sys_clk,
	input wire logic close_a,
	input wire logic close_b,
	input wire logic std_cmd,
	input wire logic [2:0] path_off,
	// monitor side
	output sim_in_s pins,
	output sim_fb_s fb
);
	logic [2:0] lag_q;
	initial begin
		pins = 3'h7;
		lag_q = 3'h7;
	end
	// contacts follow one edge late; short opens model on/off test pulses
	always @(posedge sys_clk) begin
		pins <= '{fail_safe_a: close_a, fail_safe_b: close_b, std_in: std_cmd};
		lag_q <= path_off;
	end
	// relays confirm a switched-off path a cycle late, brake relay fitted
	assign fb = '{path_fb: lag_q, brake_fitted: 1'b1};
endmodule // sim_sensor

/* File: bench/sim_monitor_tb.sv */
// sim_monitor_tb: self-checking bench of the safe input monitor.
// assumes a 1 ms tick of ten cycles and four-cycle path tests.
`timescale 1ns/10ps
module sim_monitor_tb import sim_pkg::*;;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	sim_bus_s bus = '0;
	sim_in_s pins;
	sim_fb_s fb;
	logic [31:0] rdata, rv, ex;
	logic [2:0] path_off, po;
	logic tof, req, warn, std_f;
	logic close_a = 1'b1, close_b = 1'b1, std_cmd = 1'b1;
	int errors = 0, n_tests = 0, cyc = 0, i;
	always #5 sys_clk = ~sys_clk;
	sim_monitor #(.TICK_CYCLES(10), .TEST_CYCLES(4)) sim_monitor_inst (.sys_clk(sys_clk),
		.rst(rst), .bus(bus), .rdata(rdata), .pins(pins), .fb(fb), .path_off(path_off),
		.torque_off_active_flag(tof), .selftest_required_flag(req),
		.selftest_due_warning(warn), .std_in_filtered(std_f));
	sim_sensor sim_sensor_inst (.sys_clk(sys_clk), .close_a(close_a), .close_b(close_b),
		.std_cmd(std_cmd), .path_off(path_off), .pins(pins), .fb(fb));
	task automatic end_of_test;
		if (errors == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// hang guard, well above the planned run
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors = errors + 1;
			end_of_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// bus cycles leave one idle edge so no strobe is assigned twice in a step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus.wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus.rd <= 1'b0;
		#1 rv = rdata;
		@(posedge sys_clk);
		chk(nm, e, rv);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic t_defaults;
		rchk(ADR_TOL, {16'h0, TOL_RST}, "tolerance");
		rchk(ADR_DEB, {24'h0, DEB_RST}, "safe debounce");
		rchk(ADR_IVL, IVL_RST, "interval");
		rchk(ADR_SDEB, {24'h0, SDEB_RST}, "std debounce");
		rchk(8'h20, 32'h0, "unmapped");
		wr(ADR_TGL, 32'h000064FF);
	endtask
	task automatic t_inhibit_debounce;
		close_a <= 1'b0;
		wait_n(30);
		chk("inhibited", 32'h0, {31'h0, tof});
		close_a <= 1'b1;
		wait_n(30);
		wr(ADR_CTRL, 32'h1);
		close_a <= 1'b0;
		close_b <= 1'b0;
		wait_n(5);
		close_a <= 1'b1;
		close_b <= 1'b1;
		wait_n(20);
		chk("pulse filtered", 32'h0, {31'h0, tof});
		close_a <= 1'b0;
		for (i = 0; i < 40 && tof !== 1'b1; i++) @(posedge sys_clk);
		chk("debounce delay", 32'h1, {31'h0, i >= 10 && i <= 15});
		// channel A low alone: discrepancy, torque-off and the selection test all show
		ex = 32'(1 << ST_DISC | 1 << ST_TOA | 1 << ST_TRUN | 1 << ST_FB);
		rchk(ADR_STAT, ex, "discrepancy");
	endtask
	task automatic t_fast_std;
		chk("off status", 32'h1, {31'h0, tof});
		close_a <= 1'b1;
		wait_n(30);
		wr(ADR_DEB, 32'h0);
		close_b <= 1'b0;
		std_cmd <= 1'b0;
		wait_n(5);
		chk("no delay", 32'h1, {31'h0, tof});
		chk("std held", 32'h1, {31'h0, std_f});
		wait_n(10);
		chk("std filtered", 32'h0, {31'h0, std_f});
		close_b <= 1'b1;
		wait_n(30);
	endtask
	// a lasting discrepancy and too many changes both latch torque-off until cleared
	task automatic t_faults;
		wr(ADR_TOL, 32'h2);
		close_a <= 1'b0;
		wait_n(40);
		ex = 32'(1 << ST_DISC | 1 << ST_TOA | 1 << ST_WIRE | 1 << ST_FB);
		rchk(ADR_STAT, ex, "wiring");
		close_a <= 1'b1;
		wr(ADR_TOL, {16'h0, TOL_RST});
		wait_n(3);
		chk("fault holds", 32'h1, {31'h0, tof});
		wr(ADR_CTRL, 32'h3);
		wait_n(2);
		chk("wiring cleared", 32'h0, {31'h0, tof});
		// limit of three changes; twelve raw changes overrun it even across a window edge
		wr(ADR_TGL, 32'h00006403);
		for (i = 0; i < 6; i++) begin
			close_b <= 1'b0;
			wait_n(2);
			close_b <= 1'b1;
			wait_n(2);
		end
		wait_n(40);
		ex = 32'(1 << ST_TOA | 1 << ST_TGL | 1 << ST_FA | 1 << ST_FB);
		rchk(ADR_STAT, ex, "toggle");
		wr(ADR_TGL, 32'h000064FF);
		wr(ADR_CTRL, 32'h3);
		wait_n(2);
		chk("toggle cleared", 32'h0, {31'h0, tof});
	endtask
	task automatic t_timer;
		// the ten-cycle tick counts from reset release at edge 8: start one edge after a tick
		while (cyc % 10 != 8) @(posedge sys_clk);
		wr(ADR_IVL, 32'h3);
		close_a <= 1'b0;
		wait_n(5);
		close_a <= 1'b1;
		wait_n(20);
		rchk(ADR_REM, 32'h2, "remaining");
		po = path_off;
		for (i = 0; i < 60 && warn !== 1'b1; i++) @(posedge sys_clk);
		chk("warning", 32'h1, {31'h0, warn});
		chk("paths kept", {29'h0, po}, {29'h0, path_off});
		wait_n(2);
		chk("required", 32'h1, {31'h0, req});
		close_b <= 1'b0;
		wait_n(5);
		close_b <= 1'b1;
		wait_n(25);
		chk("required cleared", 32'h0, {31'h0, req});
	endtask
	initial begin
		wait_n(8);
		rst <= 1'b0;
		wait_n(20);
		t_defaults();
		t_inhibit_debounce();
		t_fast_std();
		t_faults();
		t_timer();
		end_of_test();
	end
endmodule // sim_monitor_tb
